// *** async_write_data_drive_timing.sv ***
// Write data driver of the external bus unit for asynchronous write accesses.
// Assumes an APB master on pclk and an asynchronous memory on the ext bus pins.
`timescale 1ns/10ps
module async_write_data_drive_timing #(
    parameter int NREG = 4
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // External bus
    output logic [31:0]      ext_addr_data_bus,
    output logic             ext_ad_oe_n,
    output logic             ext_addr_valid,
    output logic             ext_cs_n,
    output logic             ext_wr_n
);

    localparam int RW   = (NREG > 1) ? $clog2(NREG) : 1;
    localparam int PH_W = ext_write_pkg::PH_LEN_W;

    // ==========================================================
    // Register state
    logic [NREG-1:0]               cfg_dly;
    logic [NREG-1:0]               cfg_fcms;
    logic [NREG-1:0][1:0]          cfg_ext;
    logic [NREG-1:0][PH_W-1:0]     cfg_cmd;
    logic [NREG-1:0][PH_W-1:0]     cfg_hold;
    logic [31:0]                   addr_reg;
    logic [31:0]                   data_reg;
    logic [RW-1:0]                 act_region;

    // Access state
    ext_write_pkg::wr_state_t      state;
    ext_write_pkg::wr_state_t      next_state;
    logic [PH_W-1:0]               cnt;
    logic [PH_W-1:0]               next_cnt;
    logic                          first;
    logic                          next_first;
    logic                          eff_dly;
    logic [1:0]                    eff_ext;
    logic [PH_W-1:0]               eff_cmd;
    logic [PH_W-1:0]               eff_hold;
    logic                          sel_dly;
    logic [1:0]                    sel_ext;
    logic                          ref_last;

    // APB decode
    logic                          acc;
    logic                          wr_ok;
    logic                          start_go;
    logic [RW-1:0]                 req_region;
    logic [31:0]                   rd_data;
    logic                          rd_err;

    // ==========================================================
    // Address decode helpers
    function automatic logic in_region(input logic [7:0] a);
        logic [7:0] rel;
        rel = a - ext_write_pkg::REGION_BASE;
        return (a >= ext_write_pkg::REGION_BASE) && (a[1:0] == 2'h0)
            && (int'(rel >> ext_write_pkg::REGION_SHIFT) < NREG);
    endfunction

    function automatic logic [RW-1:0] region_of(input logic [7:0] a);
        logic [7:0] rel;
        rel = (a - ext_write_pkg::REGION_BASE) >> ext_write_pkg::REGION_SHIFT;
        return rel[RW-1:0];
    endfunction

    // ==========================================================
    // APB slave: zero wait states, answer registered in setup cycle
    assign acc        = psel && penable && pready;
    assign wr_ok      = acc && pwrite && !pslverr;
    assign req_region = pwdata[ext_write_pkg::CTRL_REGION_LSB +: RW];
    assign start_go   = wr_ok && paddr == ext_write_pkg::CTRL_OFS
                        && pwdata[ext_write_pkg::CTRL_START_BIT]
                        && state == ext_write_pkg::ST_IDLE;

    always_comb begin
        logic [RW-1:0] r;
        r       = region_of(paddr);
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (in_region(paddr)) begin
            if (paddr[ext_write_pkg::PHASE_SEL_BIT]) begin
                rd_data[ext_write_pkg::PH_EXT_LSB +: 2]     = cfg_ext[r];
                rd_data[ext_write_pkg::PH_CMD_LSB +: PH_W]  = cfg_cmd[r];
                rd_data[ext_write_pkg::PH_HOLD_LSB +: PH_W] = cfg_hold[r];
            end else begin
                rd_data[ext_write_pkg::CFG_DLY_BIT]  = cfg_dly[r];
                rd_data[ext_write_pkg::CFG_FCMS_BIT] = cfg_fcms[r];
            end
        end else begin
            case (paddr)
                ext_write_pkg::CTRL_OFS: begin
                    // Busy refuses a new access
                    rd_err = pwrite && state != ext_write_pkg::ST_IDLE;
                end
                ext_write_pkg::ADDR_OFS: rd_data = addr_reg;
                ext_write_pkg::DATA_OFS: rd_data = data_reg;
                ext_write_pkg::STATUS_OFS: begin
                    rd_data[ext_write_pkg::STATUS_BUSY_BIT] =
                        (state != ext_write_pkg::ST_IDLE);
                    rd_data[ext_write_pkg::STATUS_REGION_LSB +: RW] = act_region;
                end
                default: rd_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && rd_err;
            prdata  <= (psel && !penable && !pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= 32'h0000_0000;
            data_reg <= 32'h0000_0000;
        end else if (wr_ok && state == ext_write_pkg::ST_IDLE) begin
            // Frozen during an access so the bus never changes mid-write
            if (paddr == ext_write_pkg::ADDR_OFS) addr_reg <= pwdata;
            if (paddr == ext_write_pkg::DATA_OFS) data_reg <= pwdata;
        end
    end

    generate
        for (genvar g = 0; g < NREG; g++) begin : g_region
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_dly[g]  <= ext_write_pkg::CFG_RESET[ext_write_pkg::CFG_DLY_BIT];
                    cfg_fcms[g] <= ext_write_pkg::CFG_RESET[ext_write_pkg::CFG_FCMS_BIT];
                    cfg_ext[g]  <= ext_write_pkg::PH_RESET[ext_write_pkg::PH_EXT_LSB +: 2];
                    cfg_cmd[g]  <= ext_write_pkg::PH_RESET[ext_write_pkg::PH_CMD_LSB +: PH_W];
                    cfg_hold[g] <= ext_write_pkg::PH_RESET[ext_write_pkg::PH_HOLD_LSB +: PH_W];
                end else if (wr_ok && in_region(paddr) && region_of(paddr) == g) begin
                    if (paddr[ext_write_pkg::PHASE_SEL_BIT]) begin
                        cfg_ext[g]  <= pwdata[ext_write_pkg::PH_EXT_LSB +: 2];
                        cfg_cmd[g]  <= pwdata[ext_write_pkg::PH_CMD_LSB +: PH_W];
                        cfg_hold[g] <= pwdata[ext_write_pkg::PH_HOLD_LSB +: PH_W];
                    end else begin
                        cfg_dly[g]  <= pwdata[ext_write_pkg::CFG_DLY_BIT];
                        cfg_fcms[g] <= pwdata[ext_write_pkg::CFG_FCMS_BIT];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Effective settings, latched when the access starts
    region_select #(.NREG(NREG), .RW(RW)) region_select_inst (
        .cfg_dly  (cfg_dly),
        .cfg_fcms (cfg_fcms),
        .cfg_ext  (cfg_ext),
        .region   (req_region),
        .sel_dly  (sel_dly),
        .sel_ext  (sel_ext)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_dly    <= 1'b0;
            eff_ext    <= ext_write_pkg::EXT_00;
            eff_cmd    <= ext_write_pkg::LEN_ONE;
            eff_hold   <= ext_write_pkg::LEN_ZERO;
            act_region <= '0;
        end else if (start_go) begin
            eff_dly    <= sel_dly;
            eff_ext    <= sel_ext;
            // Zero-length command phase is stretched to one cycle
            eff_cmd    <= (cfg_cmd[req_region] == ext_write_pkg::LEN_ZERO)
                          ? ext_write_pkg::LEN_ONE : cfg_cmd[req_region];
            eff_hold   <= cfg_hold[req_region];
            act_region <= req_region;
        end
    end

    // ==========================================================
    // Phase sequencer
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_first = 1'b0;
        ref_last   = 1'b0;
        case (state)
            ext_write_pkg::ST_IDLE: begin
                if (start_go) next_state = ext_write_pkg::ST_ADDR;
            end
            ext_write_pkg::ST_ADDR: begin
                next_state = ext_write_pkg::ST_CMD;
                next_cnt   = eff_cmd - ext_write_pkg::LEN_ONE;
                next_first = 1'b1;
            end
            ext_write_pkg::ST_CMD: begin
                if (cnt != ext_write_pkg::LEN_ZERO) begin
                    next_cnt = cnt - ext_write_pkg::LEN_ONE;
                end else if (eff_hold != ext_write_pkg::LEN_ZERO) begin
                    next_state = ext_write_pkg::ST_HOLD;
                    next_cnt   = eff_hold - ext_write_pkg::LEN_ONE;
                end else begin
                    ref_last   = 1'b1;
                    next_state = eff_dly ? ext_write_pkg::ST_EXTRA : ext_write_pkg::ST_IDLE;
                end
            end
            ext_write_pkg::ST_HOLD: begin
                if (cnt != ext_write_pkg::LEN_ZERO) begin
                    next_cnt = cnt - ext_write_pkg::LEN_ONE;
                end else begin
                    ref_last   = 1'b1;
                    next_state = eff_dly ? ext_write_pkg::ST_EXTRA : ext_write_pkg::ST_IDLE;
                end
            end
            // Half-cycle removal is not possible: a whole cycle is added
            ext_write_pkg::ST_EXTRA: next_state = ext_write_pkg::ST_IDLE;
            default: next_state = ext_write_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ext_write_pkg::ST_IDLE;
            cnt   <= ext_write_pkg::LEN_ZERO;
            first <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            first <= next_first;
        end
    end

    // ==========================================================
    // Pin drive, registered from the next phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_addr_data_bus <= 32'h0000_0000;
            ext_ad_oe_n       <= 1'b1;
            ext_addr_valid    <= 1'b0;
            ext_cs_n          <= 1'b1;
            ext_wr_n          <= 1'b1;
        end else begin
            ext_ad_oe_n    <= (next_state == ext_write_pkg::ST_IDLE);
            ext_addr_valid <= (next_state == ext_write_pkg::ST_ADDR);
            ext_cs_n       <= (next_state == ext_write_pkg::ST_IDLE);
            ext_wr_n       <= (next_state != ext_write_pkg::ST_CMD);
            if (next_state == ext_write_pkg::ST_IDLE)
                ext_addr_data_bus <= 32'h0000_0000;
            else if (next_state == ext_write_pkg::ST_ADDR)
                ext_addr_data_bus <= addr_reg;
            // Delayed data: the address lingers as invalid data for one cycle
            else if (next_first && eff_dly && eff_ext != ext_write_pkg::EXT_00)
                ext_addr_data_bus <= addr_reg;
            else
                ext_addr_data_bus <= data_reg;
        end
    end

    // ==========================================================
    // Assertions
    a_bus_on_first: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ext_write_pkg::ST_CMD && first) |-> !ext_ad_oe_n && !ext_wr_n)
        else $error("bus not driven in first command cycle");

    a_nodly_valid: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ext_write_pkg::ST_CMD && !eff_dly) |-> ext_addr_data_bus == data_reg)
        else $error("data not valid in command cycle without delay");

    a_ratio00_valid: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ext_write_pkg::ST_CMD && eff_ext == ext_write_pkg::EXT_00)
        |-> ext_addr_data_bus == data_reg)
        else $error("ratio 00 data delayed");

    a_invalid_first: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ext_write_pkg::ST_CMD && first && eff_dly
         && eff_ext != ext_write_pkg::EXT_00)
        |-> ext_addr_data_bus == addr_reg ##1 ext_addr_data_bus == data_reg && !ext_ad_oe_n)
        else $error("delayed data timing wrong");

    a_no_half_shift: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ext_write_pkg::ST_CMD && !first) |-> ext_addr_data_bus == data_reg)
        else $error("valid data shifted beyond first cycle");

    a_remove_nodly: assert property (@(posedge pclk) disable iff (!presetn)
        (ref_last && !eff_dly) |=> ext_ad_oe_n)
        else $error("data not removed after last hold cycle");

    a_remove_dly: assert property (@(posedge pclk) disable iff (!presetn)
        (ref_last && eff_dly) |=> !ext_ad_oe_n && ext_addr_data_bus == data_reg ##1 ext_ad_oe_n)
        else $error("delayed removal not exactly one clock");

    a_no_hold_ref: assert property (@(posedge pclk) disable iff (!presetn)
        (state == ext_write_pkg::ST_CMD && cnt == ext_write_pkg::LEN_ZERO
         && eff_hold == ext_write_pkg::LEN_ZERO) |-> ref_last)
        else $error("last command cycle not used as reference");

    a_region_dly: assert property (@(posedge pclk) disable iff (!presetn)
        start_go |=> eff_dly == $past(cfg_dly[req_region]) && act_region == $past(req_region))
        else $error("delay enable not from accessed region");

    a_cont_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        (start_go && cfg_fcms[0] == ext_write_pkg::FCMS_CONT) |=> eff_ext == $past(cfg_ext[0]))
        else $error("continuous clock ratio not used");

    c_delayed_data: cover property (@(posedge pclk) disable iff (!presetn)
        state == ext_write_pkg::ST_CMD && first && eff_dly && eff_ext != ext_write_pkg::EXT_00);
    c_no_hold: cover property (@(posedge pclk) disable iff (!presetn)
        ref_last && state == ext_write_pkg::ST_CMD);
    c_extra: cover property (@(posedge pclk) disable iff (!presetn)
        state == ext_write_pkg::ST_EXTRA);
    c_cont_clock: cover property (@(posedge pclk) disable iff (!presetn)
        start_go && cfg_fcms[req_region] != ext_write_pkg::FCMS_CONT
        && cfg_fcms[0] == ext_write_pkg::FCMS_CONT);

endmodule

// *** ext_mem_model.sv ***
// Asynchronous memory on the far side of the external write bus.
// Assumes registered bus outputs on pclk; it latches as a strobed memory would.
`timescale 1ns/10ps
module ext_mem_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // External bus
    input  wire logic [31:0] ext_addr_data_bus,
    input  wire logic        ext_ad_oe_n,
    input  wire logic        ext_addr_valid,
    input  wire logic        ext_cs_n,
    input  wire logic        ext_wr_n,
    // Captured write
    output logic [31:0]      got_addr,
    output logic [31:0]      got_data
);
    // ==========================================================
    // Capture
    // Last strobed cycle wins, as at the rising write strobe; no kinder
    // than a real part, so delayed data that misses the strobe is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            got_addr <= 32'h0;
            got_data <= 32'h0;
        end else if (!ext_cs_n && !ext_ad_oe_n) begin
            if (ext_addr_valid) begin
                got_addr <= ext_addr_data_bus;
            end
            if (!ext_wr_n) begin
                got_data <= ext_addr_data_bus;
            end
        end
    end
endmodule

// *** ext_write_pkg.sv ***
// Constants, register layout and state type for the asynchronous write data driver.
// Assumes a 32-bit APB register port and a multiplexed external address/data bus.
package ext_write_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] ADDR_OFS       = 8'h04;
    localparam logic [7:0] DATA_OFS       = 8'h08;
    localparam logic [7:0] STATUS_OFS     = 8'h0C;
    localparam logic [7:0] REGION_BASE    = 8'h10;
    localparam int         REGION_SHIFT   = 3;
    localparam int         PHASE_SEL_BIT  = 2;

    // ==========================================================
    // Field positions
    localparam int CTRL_START_BIT    = 0;
    localparam int CTRL_REGION_LSB   = 4;
    localparam int STATUS_BUSY_BIT   = 0;
    localparam int STATUS_REGION_LSB = 4;
    localparam int CFG_DLY_BIT       = 0;
    localparam int CFG_FCMS_BIT      = 1;
    localparam int PH_EXT_LSB        = 0;
    localparam int PH_CMD_LSB        = 4;
    localparam int PH_HOLD_LSB       = 8;
    localparam int PH_LEN_W          = 4;

    // ==========================================================
    // Reset values and encodings
    localparam logic [31:0] CFG_RESET   = 32'h0000_0002;
    localparam logic [31:0] PH_RESET    = 32'h0000_0010;
    localparam logic [1:0]  EXT_00      = 2'h0;
    localparam logic        FCMS_CONT   = 1'b0;
    localparam logic [3:0]  LEN_ONE     = 4'h1;
    localparam logic [3:0]  LEN_ZERO    = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_HOLD,
        ST_EXTRA
    } wr_state_t;

endpackage

// *** region_select.sv ***
// Picks the delay settings that apply to an access.
// Assumes per-region settings arrive as packed vectors from the register file.
`timescale 1ns/10ps
module region_select #(
    parameter int NREG = 4,
    parameter int RW   = 2
) (
    // Per-region settings
    input  wire logic [NREG-1:0]      cfg_dly,
    input  wire logic [NREG-1:0]      cfg_fcms,
    input  wire logic [NREG-1:0][1:0] cfg_ext,
    // Access
    input  wire logic [RW-1:0]        region,
    // Effective settings
    output logic                      sel_dly,
    output logic [1:0]                sel_ext
);

    // ==========================================================
    // Selection
    always_comb begin
        logic found;
        found   = 1'b0;
        sel_dly = cfg_dly[region];
        sel_ext = cfg_ext[region];
        // Lowest continuous-clock region sets the clock ratio for everyone
        for (int i = 0; i < NREG; i++) begin
            if (!found && cfg_fcms[i] == ext_write_pkg::FCMS_CONT) begin
                found   = 1'b1;
                sel_ext = cfg_ext[i];
            end
        end
    end

endmodule

// *** tb_async_write_data_drive_timing.sv ***
// Testbench of the asynchronous write data driver.
// Assumes the design, its package and the external memory model are compiled first.
`timescale 1ns/10ps
module tb_async_write_data_drive_timing;
    // ==========================================================
    // Signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] ext_addr_data_bus;
    logic        ext_ad_oe_n;
    logic        ext_addr_valid;
    logic        ext_cs_n;
    logic        ext_wr_n;
    logic [31:0] got_addr;
    logic [31:0] got_data;
    logic [31:0] sh_cfg [4];
    logic [31:0] sh_ph  [4];
    logic [31:0] q;
    logic        e;
    int          fails;
    int          n_compared;
    int          k;

    async_write_data_drive_timing #(.NREG(4)) async_write_data_drive_timing_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_addr_data_bus(ext_addr_data_bus), .ext_ad_oe_n(ext_ad_oe_n),
        .ext_addr_valid(ext_addr_valid), .ext_cs_n(ext_cs_n), .ext_wr_n(ext_wr_n));

    ext_mem_model ext_mem_model_inst (
        .pclk(pclk), .presetn(presetn), .ext_addr_data_bus(ext_addr_data_bus),
        .ext_ad_oe_n(ext_ad_oe_n), .ext_addr_valid(ext_addr_valid), .ext_cs_n(ext_cs_n),
        .ext_wr_n(ext_wr_n), .got_addr(got_addr), .got_data(got_data));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ==========================================================
    // Helpers
    task automatic finish_test();
        if (fails == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Holds the request until pready is sampled high, then releases
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic re);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            finish_test();
        end
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] cfg_adr(input int r);
        return ext_write_pkg::REGION_BASE + 8'(r << ext_write_pkg::REGION_SHIFT);
    endfunction

    // Programs a region, starts a write and follows it cycle by cycle
    task automatic run_case(input int r, input logic [31:0] cfg, input logic [31:0] ph,
                            input logic [31:0] ad, input logic [31:0] dt);
        logic [31:0] rq;
        logic        re;
        logic        dly;
        logic [1:0]  ratio;
        logic        inval;
        logic [31:0] eb;
        int          c;
        int          last;
        int          n;
        apb(1'b1, cfg_adr(r), cfg, rq, re);
        apb(1'b1, cfg_adr(r) + 8'h04, ph, rq, re);
        sh_cfg[r] = cfg;
        sh_ph[r]  = ph;
        dly   = cfg[0];
        ratio = ph[1:0];
        for (int i = 3; i >= 0; i--) begin
            if (sh_cfg[i][1] == ext_write_pkg::FCMS_CONT) begin
                ratio = sh_ph[i][1:0];
            end
        end
        c     = (ph[7:4] == 4'h0) ? 1 : int'(ph[7:4]);
        last  = c + int'(ph[11:8]) + int'(dly);
        inval = dly && (ratio != ext_write_pkg::EXT_00);
        apb(1'b1, ext_write_pkg::ADDR_OFS, ad, rq, re);
        apb(1'b1, ext_write_pkg::DATA_OFS, dt, rq, re);
        apb(1'b1, ext_write_pkg::CTRL_OFS, 32'h1 | 32'(r << 4), rq, re);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (ext_addr_valid !== 1'b1 && n < 8);
        if (ext_addr_valid !== 1'b1) begin
            fails++;
            finish_test();
        end
        for (int j = 0; j <= last + 1; j++) begin
            if (j > 0) begin
                @(posedge pclk);
            end
            eb = (j == 0 || (j == 1 && inval)) ? ad : dt;
            eb = (j > last) ? 32'h0 : eb;
            check("bus", ext_addr_data_bus, eb);
            check("oe_n", {31'h0, ext_ad_oe_n}, 32'(j > last));
            check("cs_n", {31'h0, ext_cs_n}, 32'(j > last));
            check("wr_n", {31'h0, ext_wr_n}, 32'(!(j >= 1 && j <= c)));
            check("addr_valid", {31'h0, ext_addr_valid}, 32'(j == 0));
        end
        check("mem_addr", got_addr, ad);
        check("mem_data", got_data, (c == 1 && inval) ? ad : dt);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        fails      = 0;
        n_compared = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 4; k++) begin
            sh_cfg[k] = ext_write_pkg::CFG_RESET;
            sh_ph[k]  = ext_write_pkg::PH_RESET;
            apb(1'b0, cfg_adr(k), 32'h0, q, e);
            check("cfg_reset", q, ext_write_pkg::CFG_RESET);
            apb(1'b0, cfg_adr(k) + 8'h04, 32'h0, q, e);
            check("phase_reset", q, ext_write_pkg::PH_RESET);
        end
        apb(1'b0, 8'hF0, 32'h0, q, e);
        check("unmapped_err", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h12, 32'h0, q, e);
        check("unaligned_err", {31'h0, e}, 32'h1);
        run_case(0, 32'h2, 32'h010, 32'h0000_1000, 32'hA5A5_0001);
        run_case(0, 32'h3, 32'h120, 32'h0000_1004, 32'h5A5A_0002);
        run_case(1, 32'h3, 32'h121, 32'h0000_2008, 32'hC3C3_0003);
        run_case(2, 32'h3, 32'h002, 32'h0000_300C, 32'h3C3C_0004);
        run_case(3, 32'h3, 32'h233, 32'h0000_4010, 32'hFFFF_0005);
        run_case(1, 32'h2, 32'h203, 32'h0000_5014, 32'h0F0F_0006);
        // Start refused while busy; status shows busy and region
        apb(1'b1, ext_write_pkg::CTRL_OFS, 32'h31, q, e);
        apb(1'b1, ext_write_pkg::CTRL_OFS, 32'h31, q, e);
        check("busy_refuse", {31'h0, e}, 32'h1);
        apb(1'b0, ext_write_pkg::STATUS_OFS, 32'h0, q, e);
        check("status_busy", q & 32'h31, 32'h31);
        k = 0;
        do begin
            apb(1'b0, ext_write_pkg::STATUS_OFS, 32'h0, q, e);
            k++;
        end while (q[0] !== 1'b0 && k < 20);
        check("busy_clear", {31'h0, q[0]}, 32'h0);
        if (q[0] !== 1'b0) begin
            finish_test();
        end
        // Continuous clock region overrides the accessed region's ratio
        run_case(0, 32'h1, 32'h110, 32'h0000_6018, 32'h1234_0007);
        run_case(3, 32'h3, 32'h023, 32'h0000_701C, 32'h8765_0008);
        finish_test();
    end
endmodule
